// ==== hdl/stc_edge.sv ====
// stc_edge: rising edge finder for the external count source
// assumes input synchronous; optional extra sync stage
`timescale 1ns/1ps
`default_nettype none
module stc_edge
   import stc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_bypass,
   input wire logic i_src,
   output logic o_rise
);
   logic s1_ff;
   logic s2_ff;
   logic prev_ff;
   // bypass skips the sync stage, edge seen two cycles earlier
   wire logic cur = i_bypass ? i_src : s2_ff;

   assign o_rise = cur && !prev_ff;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else if (i_ce) begin
         s1_ff <= i_src;
         s2_ff <= s1_ff;
         prev_ff <= cur;
      end
   end
endmodule : stc_edge
`default_nettype wire

// ==== hdl/stc_pkg.sv ====
// stc_pkg: constants and carrier types for the sixteen bit timer/counter
// assumes a single 10 MHz core clock and an Avalon-MM register bus
package stc_pkg;
   localparam int unsigned STC_ADDR_W = 8;
   localparam logic [7:0] STC_OFF_CTRL = 8'h10;
   localparam logic [7:0] STC_OFF_CNT_LO = 8'h14;
   localparam logic [7:0] STC_OFF_CNT_HI = 8'h18;
   localparam logic [7:0] STC_OFF_PIN_DATA = 8'h1C;
   localparam logic [7:0] STC_OFF_PIN_DIR = 8'h20;
   localparam logic [7:0] STC_OFF_PORT_DATA = 8'h24;
   localparam logic [7:0] STC_OFF_PORT_DIR = 8'h28;
   localparam logic [7:0] STC_OFF_FLAG = 8'h2C;
   localparam logic [7:0] STC_OFF_TRIG = 8'h30;
   localparam int unsigned STC_BIT_RUN = 0;
   localparam int unsigned STC_BIT_CS = 1;
   localparam int unsigned STC_BIT_SYNC = 2;
   localparam int unsigned STC_BIT_OSC = 3;
   localparam int unsigned STC_PS_LSB = 4;
   localparam logic [7:0] STC_CTRL_MASK = 8'h3F;
   localparam logic [7:0] STC_CTRL_RST = 8'h00;
   localparam logic [1:0] STC_PORT_DIR_RST = 2'h3;
   localparam logic STC_PIN_DIR_RST = 1'b1;
   localparam logic [3:0] STC_CMP_SPECIAL = 4'hB;
   localparam logic [15:0] STC_CNT_MAX = 16'hFFFF;
   localparam logic [2:0] STC_QUARTER = 3'h3;

   typedef enum logic [1:0] {
      STC_M_OFF = 2'b00,
      STC_M_TIMER = 2'b01,
      STC_M_EXT = 2'b11,
      STC_M_OSC = 2'b10
   } stc_mode_t;

   typedef struct packed {
      logic [1:0] o;
      logic [1:0] oe;
   } stc_pins_t;
endpackage : stc_pkg

// ==== hdl/stc_prescale.sv ====
// stc_prescale: 1:1 to 1:8 divider of count ticks
// assumes i_tick is one cycle wide
`timescale 1ns/1ps
`default_nettype none
module stc_prescale
   import stc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_clr,
   input wire logic [1:0] i_sel,
   input wire logic i_tick,
   output logic o_tick
);
   logic [2:0] div_ff;
   logic [2:0] nxt_div;
   wire logic [2:0] limit = 3'((1 << i_sel) - 1);

   assign o_tick = i_tick && (div_ff >= limit);
   assign nxt_div = i_clr ? 3'h0 : (o_tick ? 3'h0 : (i_tick ? div_ff + 3'h1 : div_ff));

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         div_ff <= 3'h0;
      end else if (i_ce) begin
         div_ff <= nxt_div;
      end
   end
endmodule : stc_prescale
`default_nettype wire

// ==== hdl/stc_timer.sv ====
// stc_timer: sixteen bit timer/counter with register slave and shared pins
// assumes i_ref_clk is the core oscillator; instruction cycle is 4 clocks
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - sixteen bit count, two bytes, read/write
// - wrap from all ones flags overflow
// - control bit 0 runs counting
// - timer mode counts each instruction cycle
// - counter mode counts rising edges only
// - bit 1 picks pin or internal quarter
// - bits 5:4 prescale 1,2,4,8
// - bit 2 clear syncs external clock
// - internal source ignores sync bit
// - bit 3 enables low power oscillator
// - oscillator on forces both pins input
// - control bits 7:6 read zero
// - compare unit reset clears count
// - bits 1 and 3 clear: pins are normal io
// - external circuit: count pin, bit reads pin
// - firmware clock: data bit drives pin
// - clock port bit isolated from pin
// - back to timer: latch drives pin again
// - oscillator mode: data bit reads zero
// - oscillator mode isolates both port bits
// - mode 1011 trigger resets, starts conversion
// - overflow latches flag bit 0
// - special trigger never sets overflow flag
// - software write beats trigger reset
module stc_timer
   import stc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [STC_ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic [3:0] i_cmp_mode,
   input wire logic i_cmp_trigger,
   input wire logic i_adc_enable,
   output logic o_adc_start,
   input wire logic i_ovf_irq_enable,
   output logic o_ovf_irq,
   output logic o_osc_enable,
   input wire logic i_osc_clk,
   input wire logic [1:0] i_pin,
   output logic [1:0] o_pin,
   output logic [1:0] o_pin_oe
);
   logic [5:0] ctrl_ff;
   logic [15:0] cnt_ff;
   logic [1:0] port_lat_ff;
   logic [1:0] port_dir_ff;
   logic pin_lat_ff;
   logic pin_dir_ff;
   logic flag_ff;
   logic [2:0] phase_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic adc_ff;
   stc_pins_t pins;

   wire logic run = ctrl_ff[STC_BIT_RUN];
   wire logic cs = ctrl_ff[STC_BIT_CS];
   wire logic no_sync = ctrl_ff[STC_BIT_SYNC];
   wire logic osc_en = ctrl_ff[STC_BIT_OSC];
   wire logic [1:0] ps_sel = ctrl_ff[STC_PS_LSB+1:STC_PS_LSB];
   wire stc_mode_t mode = !run ? STC_M_OFF : (!cs ? STC_M_TIMER : (osc_en ? STC_M_OSC : STC_M_EXT));

   // bus decode: one wait cycle, answer on the second edge
   wire logic req = (i_read || i_write) && !ack_ff;
   wire logic wr = i_write && ack_ff;
   wire logic hit_ctrl = i_address == STC_OFF_CTRL;
   wire logic hit_lo = i_address == STC_OFF_CNT_LO;
   wire logic hit_hi = i_address == STC_OFF_CNT_HI;
   wire logic hit_pdat = i_address == STC_OFF_PIN_DATA;
   wire logic hit_pdir = i_address == STC_OFF_PIN_DIR;
   wire logic hit_port = i_address == STC_OFF_PORT_DATA;
   wire logic hit_pdr = i_address == STC_OFF_PORT_DIR;
   wire logic hit_flag = i_address == STC_OFF_FLAG;
   wire logic cnt_wr = wr && (hit_lo || hit_hi);

   // clock pin belongs to the counter whenever the pin source is picked
   wire logic ext_sel = cs;
   wire logic pin1_isolated = cs || osc_en;
   wire logic pin2_isolated = osc_en;
   wire logic firmware_clk = cs && !osc_en && !pin_dir_ff;
   wire logic ext_src = osc_en ? i_osc_clk : (firmware_clk ? pin_lat_ff : i_pin[0]);
   wire logic ext_rise;
   wire logic int_tick = phase_ff == STC_QUARTER;
   wire logic raw_tick = ext_sel ? ext_rise : int_tick;
   wire logic ps_tick;
   wire logic inc = (mode != STC_M_OFF) && ps_tick;
   wire logic wrap = inc && (cnt_ff == STC_CNT_MAX);
   wire logic special = i_cmp_trigger && (i_cmp_mode == STC_CMP_SPECIAL);

   stc_edge u_edge (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_bypass(no_sync && ext_sel),
      .i_src(ext_src),
      .o_rise(ext_rise)
   );

   stc_prescale u_ps (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_clr(cnt_wr),
      .i_sel(ps_sel),
      .i_tick(raw_tick && run),
      .o_tick(ps_tick)
   );

   // count next value: write first, then trigger, then increment
   logic [15:0] nxt_cnt;
   always_comb begin
      nxt_cnt = cnt_ff;
      if (cnt_wr && hit_lo) begin
         nxt_cnt[7:0] = i_writedata[7:0];
      end else if (cnt_wr && hit_hi) begin
         nxt_cnt[15:8] = i_writedata[7:0];
      end else if (special) begin
         nxt_cnt = 16'h0000;
      end else if (inc) begin
         nxt_cnt = cnt_ff + 16'h0001;
      end
   end

   // flag: overflow set beats software clear; trigger reset never sets it
   wire logic ovf_set = wrap && !cnt_wr && !special;
   wire logic flag_clr = wr && hit_flag && i_writedata[0];
   wire logic nxt_flag = ovf_set || (flag_ff && !flag_clr);

   // pin drive
   always_comb begin
      pins.o = port_lat_ff;
      pins.oe = ~port_dir_ff;
      if (pin1_isolated) begin
         pins.o[0] = pin_lat_ff;
         pins.oe[0] = firmware_clk;
      end
      if (pin2_isolated) begin
         pins.oe[1] = 1'b0;
      end
      if (osc_en) begin
         pins.oe = 2'b00;
      end
   end
   assign o_pin = pins.o;
   assign o_pin_oe = pins.oe;

   // port readback: isolated inputs read zero, outputs read latch
   wire logic [1:0] port_rd;
   assign port_rd[0] = port_dir_ff[0] ? (pin1_isolated ? 1'b0 : i_pin[0]) : port_lat_ff[0];
   assign port_rd[1] = port_dir_ff[1] ? (pin2_isolated ? 1'b0 : i_pin[1]) : port_lat_ff[1];
   wire logic pdat_rd = osc_en ? 1'b0 : (firmware_clk ? pin_lat_ff : i_pin[0]);

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (hit_ctrl) begin
         rd_mux = {2'b00, ctrl_ff};
      end else if (hit_lo) begin
         rd_mux = cnt_ff[7:0];
      end else if (hit_hi) begin
         rd_mux = cnt_ff[15:8];
      end else if (hit_pdat) begin
         rd_mux = {7'h00, pdat_rd};
      end else if (hit_pdir) begin
         rd_mux = {7'h00, pin_dir_ff};
      end else if (hit_port) begin
         rd_mux = {6'h00, port_rd};
      end else if (hit_pdr) begin
         rd_mux = {6'h00, port_dir_ff};
      end else if (hit_flag) begin
         rd_mux = {7'h00, flag_ff};
      end
   end

   assign o_waitrequest = (i_read || i_write) && !ack_ff;
   assign o_readdata = rdata_ff;
   assign o_ovf_irq = flag_ff && i_ovf_irq_enable;
   assign o_osc_enable = osc_en;
   assign o_adc_start = adc_ff;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else if (i_ce) begin
         ack_ff <= req;
         rdata_ff <= (req && i_read) ? {24'h00_0000, rd_mux} : rdata_ff;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ctrl_ff <= STC_CTRL_RST[5:0];
         cnt_ff <= 16'h0000;
         flag_ff <= 1'b0;
         phase_ff <= 3'h0;
         adc_ff <= 1'b0;
      end else if (i_ce) begin
         if (wr && hit_ctrl) begin
            ctrl_ff <= i_writedata[5:0] & STC_CTRL_MASK[5:0];
         end
         cnt_ff <= nxt_cnt;
         flag_ff <= nxt_flag;
         phase_ff <= int_tick ? 3'h0 : phase_ff + 3'h1;
         adc_ff <= special && i_adc_enable;
      end
   end

   // latches take writes, except pin data while the oscillator is on; drive is decided by mode above
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         port_lat_ff <= 2'h0;
         port_dir_ff <= STC_PORT_DIR_RST;
         pin_lat_ff <= 1'b0;
         pin_dir_ff <= STC_PIN_DIR_RST;
      end else if (i_ce) begin
         if (wr && hit_port) begin
            port_lat_ff <= i_writedata[1:0];
         end
         if (wr && hit_pdr) begin
            port_dir_ff <= i_writedata[1:0];
         end
         if (wr && hit_pdat && !osc_en) begin
            pin_lat_ff <= i_writedata[0];
         end
         if (wr && hit_pdir) begin
            pin_dir_ff <= i_writedata[0];
         end
      end
   end
endmodule : stc_timer
`default_nettype wire

// ==== tb/stc_src_model.sv ====
// stc_src_model: external clock or crystal feeding the counter
// assumes a go pulse before use; stands low between bursts
`timescale 1ns/1ps
`default_nettype none
module stc_src_model (
   input wire logic i_ref_clk,
   input wire logic i_go,
   input wire logic [3:0] i_half,
   input wire logic [7:0] i_edges,
   output logic o_clk,
   output logic o_busy
);
   logic [7:0] left_ff;
   logic [3:0] tick_ff;
   assign o_busy = left_ff != 8'h00;
   // slow half periods keep each level visible past the sync stages
   always_ff @(posedge i_ref_clk) begin
      if (i_go) begin
         left_ff <= i_edges;
         tick_ff <= 4'h0;
         o_clk <= 1'b0;
      end else if (o_busy) begin
         if (tick_ff == i_half) begin
            tick_ff <= 4'h0;
            o_clk <= !o_clk;
            if (o_clk) left_ff <= left_ff - 8'h01;
         end else begin
            tick_ff <= tick_ff + 4'h1;
         end
      end
   end
endmodule : stc_src_model
`default_nettype wire

// ==== tb/stc_timer_assertions.sv ====
// stc_chk: port checks for stc_timer, bound into every instance
// assumes no bus request or trigger while i_ce is low
`timescale 1ns/1ps
`default_nettype none
module stc_chk
   import stc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic o_waitrequest,
   input wire logic [31:0] o_readdata,
   input wire logic [3:0] i_cmp_mode,
   input wire logic i_cmp_trigger,
   input wire logic i_adc_enable,
   input wire logic o_adc_start,
   input wire logic i_ovf_irq_enable,
   input wire logic o_ovf_irq,
   input wire logic o_osc_enable,
   input wire logic [1:0] o_pin_oe
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   wire logic req = i_read || i_write;
   wire logic spc = i_cmp_trigger && i_cmp_mode == STC_CMP_SPECIAL;
   sequence s_new; req && !$past(req); endsequence
   sequence s_ack; o_waitrequest ##1 !o_waitrequest; endsequence
   chk_req_wait: assert property (s_new |-> s_ack)
      else $error("bus request not answered after one wait cycle");
   chk_idle_ready: assert property (!req |-> !o_waitrequest)
      else $error("waitrequest high while idle");
   chk_read_upper: assert property (o_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   chk_adc_start: assert property (spc && i_adc_enable |=> o_adc_start)
      else $error("conversion start missing after trigger");
   chk_adc_cause: assert property (o_adc_start |-> $past(spc) && $past(i_adc_enable))
      else $error("conversion start without trigger");
   chk_irq_mask: assert property (!i_ovf_irq_enable |-> !o_ovf_irq)
      else $error("masked overflow interrupt raised");
   chk_trig_noflag: assert property ($rose(o_ovf_irq) && $past(i_ovf_irq_enable) |-> !$past(spc))
      else $error("overflow flag set by trigger reset");
   chk_osc_inputs: assert property (o_osc_enable |-> o_pin_oe == 2'b00)
      else $error("pin driven while oscillator on");
endmodule : stc_chk
bind stc_timer stc_chk u_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_read(i_read), .i_write(i_write),
   .o_waitrequest(o_waitrequest), .o_readdata(o_readdata), .i_cmp_mode(i_cmp_mode),
   .i_cmp_trigger(i_cmp_trigger), .i_adc_enable(i_adc_enable), .o_adc_start(o_adc_start),
   .i_ovf_irq_enable(i_ovf_irq_enable), .o_ovf_irq(o_ovf_irq), .o_osc_enable(o_osc_enable),
   .o_pin_oe(o_pin_oe));
`default_nettype wire

// ==== tb/stc_timer_tb_top.sv ====
// stc_timer_tb_top: self-checking bench for stc_timer
// assumes stc_src_model drives the clock pin and crystal input
`timescale 1ns/1ps
`default_nettype none
module stc_timer_tb_top
   import stc_pkg::*;
;
   logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, trig = 1'b0, adc = 1'b0, irqen = 1'b0, go = 1'b1;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00, edges = 8'h00;
   logic [31:0] wd = 32'h0, rdv, rdata;
   logic [3:0] mode = 4'h0, half = 4'h3;
   logic wreq, adcs, irq, osce, sclk, busy;
   logic [1:0] pin, oe;
   // released clock pin follows the source, osc input pin has a pull-up
   wire logic [1:0] lvl = {oe[1] ? pin[1] : 1'b1, oe[0] ? pin[0] : sclk};
   int mismatches = 0, comparisons = 0;
   stc_timer dut (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_address(addr), .i_read(rd), .i_write(wr),
      .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wreq), .i_cmp_mode(mode), .i_cmp_trigger(trig),
      .i_adc_enable(adc), .o_adc_start(adcs), .i_ovf_irq_enable(irqen), .o_ovf_irq(irq),
      .o_osc_enable(osce), .i_osc_clk(sclk), .i_pin(lvl), .o_pin(pin), .o_pin_oe(oe));
   stc_src_model src (.i_ref_clk(clk), .i_go(go), .i_half(half), .i_edges(edges), .o_clk(sclk), .o_busy(busy));
   initial forever #50 clk = ~clk;
   task check(input string n, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : check
   // waitrequest and read data taken together at the rising edge, pre-update values
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic ok;
      ok = 1'b0;
      @(posedge clk);
      addr <= a;
      wd <= {24'h0, d};
      wr <= w;
      rd <= !w;
      while (!ok) begin
         @(posedge clk);
         ok = wreq === 1'b0;
         rdv = rdata;
      end
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task rc(input string n, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(n, rdv[15:0], {8'h00, e});
   endtask : rc
   task srcrun(input logic [7:0] n, input logic [3:0] h);
      @(posedge clk);
      go <= 1'b1;
      edges <= n;
      half <= h;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      repeat (400) if (busy) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask : srcrun
   task t_regs;
      rc("ctrl rst", 8'h10, 8'h00);
      rc("port dir rst", 8'h28, 8'h03);
      rc("pin dir rst", 8'h20, 8'h01);
      bus(1'b1, 8'h30, 8'hFF);
      rc("unmapped", 8'h30, 8'h00);
      bus(1'b1, 8'h10, 8'hFF);
      rc("ctrl bits", 8'h10, 8'h3F);
      bus(1'b1, 8'h10, 8'h00);
   endtask : t_regs
   task t_prescale;
      logic [7:0] n;
      for (int ps = 0; ps < 4; ps++) begin
         bus(1'b1, 8'h14, 8'h00);
         bus(1'b1, 8'h18, 8'h00);
         bus(1'b1, 8'h10, {2'b00, 2'(ps), 1'b0, ps[0], 2'b01});
         repeat (40 << ps) @(posedge clk);
         bus(1'b1, 8'h10, 8'h00);
         bus(1'b0, 8'h14, 8'h00);
         n = rdv[7:0];
         check("prescale", 16'(n >= 8'h09 && n <= 8'h0B), 16'h0001);
         repeat (40) @(posedge clk);
         rc("held", 8'h14, n);
      end
   endtask : t_prescale
   task t_ovf;
      irqen <= 1'b1;
      bus(1'b1, 8'h18, 8'hFF);
      bus(1'b1, 8'h14, 8'hFE);
      bus(1'b1, 8'h10, 8'h01);
      repeat (16) @(posedge clk);
      bus(1'b1, 8'h10, 8'h00);
      rc("wrap hi", 8'h18, 8'h00);
      rc("flag", 8'h2C, 8'h01);
      @(negedge clk);
      check("irq on", {15'h0, irq}, 16'h0001);
      @(posedge clk);
      irqen <= 1'b0;
      @(negedge clk);
      check("irq masked", {15'h0, irq}, 16'h0000);
      bus(1'b1, 8'h2C, 8'h01);
      rc("flag clear", 8'h2C, 8'h00);
   endtask : t_ovf
   task t_trig(input logic [3:0] m, input logic [7:0] e);
      bus(1'b1, 8'h14, 8'h34);
      adc <= 1'b1;
      mode <= m;
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      @(negedge clk);
      check("adc start", {15'h0, adcs}, {15'h0, e == 8'h00});
      rc("trig count", 8'h14, e);
      rc("trig no flag", 8'h2C, 8'h00);
      // trigger held across the whole write, so it meets the landing edge
      trig <= 1'b1;
      bus(1'b1, 8'h14, 8'h5A);
      trig <= 1'b0;
      rc("write wins", 8'h14, 8'h5A);
   endtask : t_trig
   // four enabled edges with run set give exactly one instruction tick
   task t_freeze;
      bus(1'b1, 8'h14, 8'h00);
      bus(1'b1, 8'h10, 8'h01);
      @(posedge clk);
      ce <= 1'b0;
      repeat (40) @(posedge clk);
      ce <= 1'b1;
      bus(1'b1, 8'h10, 8'h00);
      rc("frozen", 8'h14, 8'h01);
   endtask : t_freeze
   task t_ext;
      bus(1'b1, 8'h20, 8'h00);
      bus(1'b1, 8'h14, 8'h00);
      bus(1'b1, 8'h10, 8'h03);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 8'h1C, 8'h01);
         @(negedge clk);
         check("fw pin", {14'h0, oe[0], pin[0]}, 16'h0003);
         bus(1'b1, 8'h1C, 8'h00);
      end
      rc("fw count", 8'h14, 8'h04);
      bus(1'b1, 8'h24, 8'h01);
      rc("port in", 8'h24, 8'h02);
      bus(1'b1, 8'h20, 8'h01);
      srcrun(8'h05, 4'h3);
      bus(1'b1, 8'h10, 8'h07);
      srcrun(8'h03, 4'h2);
      rc("ext count", 8'h14, 8'h0C);
   endtask : t_ext
   task t_osc;
      bus(1'b1, 8'h14, 8'h00);
      bus(1'b1, 8'h10, 8'h0B);
      @(negedge clk);
      check("osc pins", {13'h0, osce, oe}, 16'h0004);
      srcrun(8'h06, 4'h6);
      rc("osc count", 8'h14, 8'h06);
      bus(1'b1, 8'h1C, 8'h01);
      rc("osc data bit", 8'h1C, 8'h00);
      bus(1'b1, 8'h28, 8'h00);
      bus(1'b1, 8'h24, 8'h02);
      bus(1'b0, 8'h24, 8'h00);
      check("osc latch", {12'h0, rdv[1:0], oe}, 16'h0008);
      bus(1'b1, 8'h10, 8'h01);
      @(negedge clk);
      check("io back", {11'h0, osce, oe, pin}, 16'h000E);
   endtask : t_osc
   task give_verdict;
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict;
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      go <= 1'b0;
      t_regs;
      t_prescale;
      t_ovf;
      t_trig(STC_CMP_SPECIAL, 8'h00);
      t_trig(4'hA, 8'h34);
      t_freeze;
      t_ext;
      t_osc;
      give_verdict;
   end
endmodule : stc_timer_tb_top
`default_nettype wire
